// ---- common/emc_consts.svh ----
// Purpose: Constants for the extended mode configuration link.
// Assumes: Mode words are 19 bits: bank bits 18:16 over address bits 15:0.
// Notes: Field positions, selectors and timing counts live here.
`ifndef EMC_CONSTS_SVH
`define EMC_CONSTS_SVH
`define EMC_WORD_W 19
`define EMC_SEL_ONE 3'h1
`define EMC_SEL_TWO 3'h2
`define EMC_ONE_RSVD_MASK 19'h4E500
`define EMC_TWO_RSVD_MASK 19'h4F907
`define EMC_ONE_DLL_OFF_BIT 0
`define EMC_ONE_DRV_LO_BIT 1
`define EMC_ONE_DRV_HI_BIT 5
`define EMC_ONE_TERM_B0 2
`define EMC_ONE_TERM_B1 6
`define EMC_ONE_TERM_B2 9
`define EMC_ONE_AL_LO 3
`define EMC_ONE_WLEVEL_BIT 7
`define EMC_ONE_TSTROBE_BIT 11
`define EMC_ONE_QOFF_BIT 12
`define EMC_TWO_CWL_LO 3
`define EMC_TWO_ASR_BIT 6
`define EMC_TWO_SRT_BIT 7
`define EMC_TWO_WRTERM_LO 9
`define EMC_DLL_OFF_LAT 4'h6
`define EMC_CWL_BASE 4'h5
`define EMC_MRD_CYC 4'h4
`define EMC_MOD_CYC 4'hC
`define EMC_ADDR_CTRL 2'h0
`define EMC_ADDR_WDATA 2'h1
`define EMC_ADDR_STAT 2'h2
`define EMC_CTRL_SR_BIT 1
`define EMC_CTRL_ODT_BIT 2
`define EMC_CTRL_WB_BIT 3
`define EMC_CTRL_RB_BIT 4
`define EMC_ONE_INIT 19'h10000
`define EMC_TWO_INIT 19'h20000
`endif

// ---- common/emc_pkg.sv ----
// Purpose: Types shared by both ends of the mode configuration link.
// Assumes: Constants come from emc_consts.svh.
// Notes: Word type holds bank select over address bits.
package emc_pkg;
  typedef logic [18:0] emc_word_type;
  typedef enum logic [2:0] {
    EMC_IDLE = 3'b001,
    EMC_ISSUE = 3'b010,
    EMC_WAIT = 3'b100
  } emc_state_type;
endpackage : emc_pkg

// ---- common/emc_link_if.sv ----
// Purpose: Command link between controller and mode configuration logic.
// Assumes: One clock, sys_clk, shared by both ends.
// Notes: Mode write is a one-cycle strobe with its word.
`timescale 1ns/1ps
interface emc_link_if;
  logic mode_wr;
  logic [18:0] mode_word;
  logic banks_idle;
  logic self_refresh;
  logic odt_pin;
  logic write_burst;
  logic read_burst;
  modport device (input mode_wr, mode_word, self_refresh, odt_pin, write_burst,
    read_burst, output banks_idle);
  modport ctrl (output mode_wr, mode_word, self_refresh, odt_pin, write_burst,
    read_burst, input banks_idle);
endinterface : emc_link_if

// ---- core/emc_delay_timer.sv ----
// Purpose: Down counter that holds off commands after a mode write.
// Assumes: Load is a one-cycle pulse.
// Notes: Busy is high while the count is nonzero.
`timescale 1ns/1ps
`include "emc_consts.svh"
module emc_delay_timer #(
  parameter int CNT_W = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Control.
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic busy
);
  logic [CNT_W-1:0] cnt_r;

  // The hold-off count must fit; a narrower counter would wrap and cut the wait short.
  if (CNT_W < 4) begin : g_cnt_w_check
    $error("emc_delay_timer: CNT_W too small");
  end

  // Count down to zero; a reload restarts the hold-off.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
endmodule : emc_delay_timer

// ---- core/emc_ctrl_end.sv ----
// Purpose: Controller end: issues mode writes ordered by software.
// Assumes: Software uses the plain register port, read data one cycle later.
// Notes: Reserved bits are forced to zero before a word goes out.
`timescale 1ns/1ps
`include "emc_consts.svh"
module emc_ctrl_end (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Software port.
  input wire logic [1:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Link.
  emc_link_if.ctrl link
);
  import emc_pkg::*;

  emc_state_type state_r;
  emc_word_type word_r;
  logic wr_r;
  logic go;
  logic busy;
  logic [31:0] rdata_r;
  logic sr_r;
  logic odt_r;
  logic wb_r;
  logic rb_r;

  // Sanitise a word: clear reserved bits, keep DLL on, keep strobe off on x16.
  function automatic emc_word_type clean(input emc_word_type w, input logic x16);
    emc_word_type m;
    m = w;
    if (w[18:16] == `EMC_SEL_ONE) begin
      m = w & ~`EMC_ONE_RSVD_MASK;
      m[`EMC_ONE_DLL_OFF_BIT] = 1'b0;
      if (x16) m[`EMC_ONE_TSTROBE_BIT] = 1'b0;
    end else if (w[18:16] == `EMC_SEL_TWO) begin
      m = w & ~`EMC_TWO_RSVD_MASK;
      if (w[`EMC_TWO_ASR_BIT]) m[`EMC_TWO_SRT_BIT] = 1'b0;
    end
    return m;
  endfunction : clean

  assign go = sw_wr && (sw_addr == `EMC_ADDR_CTRL) && sw_wdata[0];

  // Hold-off after each write covers both mode delays.
  emc_delay_timer #(.CNT_W(4)) u_tmr (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(wr_r),
    .load_val(`EMC_MOD_CYC),
    .busy(busy)
  );

  // Word register loaded by software.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      word_r <= `EMC_ONE_INIT;
    end else if (sw_wr && sw_addr == `EMC_ADDR_WDATA) begin
      word_r <= clean(sw_wdata[18:0], sw_wdata[31]);
    end
  end

  // Link levels follow the control word; go in bit 0 is a strobe and is not kept.
  // Termination is dropped whenever a read burst is ordered, so software cannot break it.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sr_r <= 1'b0;
      odt_r <= 1'b0;
      wb_r <= 1'b0;
      rb_r <= 1'b0;
    end else if (sw_wr && sw_addr == `EMC_ADDR_CTRL) begin
      sr_r <= sw_wdata[`EMC_CTRL_SR_BIT];
      odt_r <= sw_wdata[`EMC_CTRL_ODT_BIT] && !sw_wdata[`EMC_CTRL_RB_BIT];
      wb_r <= sw_wdata[`EMC_CTRL_WB_BIT];
      rb_r <= sw_wdata[`EMC_CTRL_RB_BIT];
    end
  end

  // Issue only when banks idle and the previous hold-off has run out.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= EMC_IDLE;
      wr_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      unique case (state_r)
        EMC_IDLE: if (go) state_r <= EMC_ISSUE;
        EMC_ISSUE: begin
          if (link.banks_idle && !busy && !sr_r && !wb_r && !rb_r) begin
            wr_r <= 1'b1;
            state_r <= EMC_WAIT;
          end
        end
        EMC_WAIT: if (!wr_r && !busy) state_r <= EMC_IDLE;
        default: state_r <= EMC_IDLE;
      endcase
    end
  end

  // Read data one cycle after the strobe.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (sw_rd) begin
      rdata_r <= (sw_addr == `EMC_ADDR_WDATA) ? {13'h0, word_r} :
                 (sw_addr == `EMC_ADDR_STAT) ? {29'h0, state_r} : 32'h0;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign sw_rdata = rdata_r;
  assign link.mode_wr = wr_r;
  assign link.mode_word = word_r;
  assign link.self_refresh = sr_r;
  assign link.odt_pin = odt_r;
  assign link.write_burst = wb_r;
  assign link.read_burst = rb_r;
endmodule : emc_ctrl_end

// ---- core/emc_device_end.sv ----
// Purpose: Device end: holds extended mode words one and two, drives controls.
// Assumes: Controller honours idle and delay constraints on mode writes.
// Notes: Memory array is outside; mode writes never touch it.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "emc_consts.svh"
module emc_device_end #(
  parameter bit X8_PART = 1'b1,
  parameter int CL = 6
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link.
  emc_link_if.device link,
  // Device controls.
  output logic dll_on,
  output logic dll_reset,
  output logic [1:0] drive_sel,
  output logic dq_out_en_n,
  output logic tstrobe_term,
  output logic dm_enable,
  output logic [3:0] term_div,
  output logic [3:0] add_lat,
  output logic [3:0] write_lat,
  output logic self_refresh_2x_auto,
  output logic self_refresh_2x_forced
);
  import emc_pkg::*;

  emc_word_type one_r;
  emc_word_type two_r;
  logic dll_on_r;
  logic dll_reset_r;
  logic sr_d_r;
  logic [1:0] drive_r;
  logic qoff_r;
  logic ts_r;
  logic dm_r;
  logic [3:0] div_r;
  logic [3:0] al_r;
  logic [3:0] wl_r;
  logic asr_r;
  logic srt_r;
  logic [2:0] nom_code;
  logic [1:0] wr_code;
  logic [3:0] al_nxt;

  // ****************************************
  // Parameter checks
  // ****************************************
  // Read latencies outside this span have no meaning for the additive latency field.
  if (CL < 5 || CL > 14) begin : g_cl_check
    $error("emc_device_end: CL out of range");
  end

  // ****************************************
  // Decode functions
  // ****************************************
  // Divisor from a nominal termination code; zero means off.
  function automatic logic [3:0] nom_div(input logic [2:0] c);
    unique case (c)
      3'h1: return 4'h4;
      3'h2: return 4'h2;
      3'h3: return 4'h6;
      3'h4: return 4'hC;
      3'h5: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction : nom_div

  // Divisor from a write termination code; zero means dynamic switching off.
  function automatic logic [3:0] wr_div(input logic [1:0] c);
    unique case (c)
      2'h1: return 4'h4;
      2'h2: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction : wr_div

  // ****************************************
  // Link tie and field picks
  // ****************************************
  // The array sits outside this block, so the banks are always reported idle.
  assign link.banks_idle = 1'b1;
  assign nom_code = {one_r[`EMC_ONE_TERM_B2], one_r[`EMC_ONE_TERM_B1],
                     one_r[`EMC_ONE_TERM_B0]};
  assign wr_code = two_r[`EMC_TWO_WRTERM_LO +: 2];

  // ****************************************
  // Mode word storage
  // ****************************************
  // Store mode words; only a mode write or reset changes them.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      one_r <= `EMC_ONE_INIT;
      two_r <= `EMC_TWO_INIT;
    end else if (link.mode_wr) begin
      if (link.mode_word[18:16] == `EMC_SEL_ONE) one_r <= link.mode_word;
      if (link.mode_word[18:16] == `EMC_SEL_TWO) two_r <= link.mode_word;
    end
  end

  // ****************************************
  // DLL control
  // ****************************************
  // DLL follows bit 0, stops in self refresh and resets after if it was on.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dll_on_r <= 1'b0;
      dll_reset_r <= 1'b0;
      sr_d_r <= 1'b0;
    end else begin
      sr_d_r <= link.self_refresh;
      dll_on_r <= !one_r[`EMC_ONE_DLL_OFF_BIT] && !link.self_refresh;
      dll_reset_r <= sr_d_r && !link.self_refresh &&
                     !one_r[`EMC_ONE_DLL_OFF_BIT];
    end
  end

  // ****************************************
  // Additive latency
  // ****************************************
  // Shared by both latency outputs so they can never disagree.
  assign al_nxt = (one_r[`EMC_ONE_AL_LO +: 2] == 2'h1) ? 4'(CL - 1) :
                  (one_r[`EMC_ONE_AL_LO +: 2] == 2'h2) ? 4'(CL - 2) : 4'h0;

  // ****************************************
  // Driver controls
  // ****************************************
  // Output driver, tri-state, strobe termination and mask.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drive_r <= 2'h0;
      qoff_r <= 1'b0;
      ts_r <= 1'b0;
      dm_r <= 1'b1;
    end else begin
      drive_r <= {one_r[`EMC_ONE_DRV_HI_BIT], one_r[`EMC_ONE_DRV_LO_BIT]};
      qoff_r <= one_r[`EMC_ONE_QOFF_BIT];
      ts_r <= X8_PART && one_r[`EMC_ONE_TSTROBE_BIT];
      dm_r <= !(X8_PART && one_r[`EMC_ONE_TSTROBE_BIT]);
    end
  end

  // ****************************************
  // Termination
  // ****************************************
  // Effective termination: pin-gated nominal, write swap, none on reads.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_r <= 4'h0;
    end else if (link.read_burst || one_r[`EMC_ONE_DLL_OFF_BIT]) begin
      div_r <= 4'h0;
    end else if (link.write_burst && wr_div(wr_code) != 4'h0 &&
                 !one_r[`EMC_ONE_WLEVEL_BIT]) begin
      div_r <= wr_div(wr_code);
    end else if (one_r[`EMC_ONE_WLEVEL_BIT] && !one_r[`EMC_ONE_QOFF_BIT] &&
                 nom_code > 3'h3) begin
      div_r <= 4'h0;
    end else begin
      div_r <= link.odt_pin ? nom_div(nom_code) : 4'h0;
    end
  end

  // ****************************************
  // Latencies
  // ****************************************
  // Latencies and self refresh rate controls.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      al_r <= 4'h0;
      wl_r <= `EMC_CWL_BASE;
      asr_r <= 1'b0;
      srt_r <= 1'b0;
    end else begin
      al_r <= al_nxt;
      wl_r <= 4'(`EMC_CWL_BASE + 4'(two_r[`EMC_TWO_CWL_LO +: 3]) + al_nxt);
      asr_r <= two_r[`EMC_TWO_ASR_BIT];
      srt_r <= two_r[`EMC_TWO_SRT_BIT] && !two_r[`EMC_TWO_ASR_BIT];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every device control output leaves straight from its register; banks_idle is tied above.
  assign dll_on = dll_on_r;
  assign dll_reset = dll_reset_r;
  assign drive_sel = drive_r;
  assign dq_out_en_n = qoff_r;
  assign tstrobe_term = ts_r;
  assign dm_enable = dm_r;
  assign term_div = div_r;
  assign add_lat = al_r;
  assign write_lat = wl_r;
  assign self_refresh_2x_auto = asr_r;
  assign self_refresh_2x_forced = srt_r;
endmodule : emc_device_end

// ---- verif/emc_link_chk.sv ----
// Purpose: Watches the mode link between the controller end and the device end.
// Assumes: Sees only the interface signals, sys_clk and reset.
// Notes: The gap counter saturates so that long idle spans never wrap it.
`timescale 1ns/1ps
`include "emc_consts.svh"
module emc_link_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link.
  input wire logic mode_wr,
  input wire logic [18:0] mode_word,
  input wire logic banks_idle,
  input wire logic self_refresh,
  input wire logic odt_pin,
  input wire logic write_burst,
  input wire logic read_burst
);
  logic [3:0] gap_r;
  logic [2:0] sel;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Helpers
  // ****************************************
  // The select field picks which word a write lands in.
  assign sel = mode_word[18:16];
  // Cycles since the last mode write; holding at the top avoids a false wrap.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) gap_r <= 4'hF;
    else if (mode_wr) gap_r <= 4'h0;
    else if (gap_r != 4'hF) gap_r <= gap_r + 4'h1;
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_one_rsvd;
    mode_wr && sel == `EMC_SEL_ONE |-> (mode_word & `EMC_ONE_RSVD_MASK) == 19'h0;
  endproperty
  a_one_rsvd: assert property (p_one_rsvd) else $error("word one reserved bit set");
  property p_two_rsvd;
    mode_wr && sel == `EMC_SEL_TWO |-> (mode_word & `EMC_TWO_RSVD_MASK) == 19'h0;
  endproperty
  a_two_rsvd: assert property (p_two_rsvd) else $error("word two reserved bit set");
  property p_dll_kept;
    mode_wr && sel == `EMC_SEL_ONE |-> !mode_word[`EMC_ONE_DLL_OFF_BIT];
  endproperty
  a_dll_kept: assert property (p_dll_kept) else $error("word one turns the DLL off");
  property p_odt_read;
    read_burst |-> !odt_pin;
  endproperty
  a_odt_read: assert property (p_odt_read) else $error("termination during read");
  property p_gap;
    mode_wr |-> gap_r >= 4'hC;
  endproperty
  a_gap: assert property (p_gap) else $error("mode writes too close together");
  property p_pulse;
    mode_wr |=> !mode_wr;
  endproperty
  a_pulse: assert property (p_pulse) else $error("mode write longer than one cycle");
  property p_idle;
    mode_wr |-> banks_idle && !self_refresh;
  endproperty
  a_idle: assert property (p_idle) else $error("mode write while not idle");
  property p_no_burst;
    mode_wr |-> !read_burst && !write_burst;
  endproperty
  a_no_burst: assert property (p_no_burst) else $error("mode write during a burst");
  property p_sr_rates;
    mode_wr && sel == `EMC_SEL_TWO |-> !(mode_word[6] && mode_word[7]);
  endproperty
  a_sr_rates: assert property (p_sr_rates) else $error("both refresh rate bits set");
  // Main traffic kinds.
  c_one: cover property (mode_wr && sel == `EMC_SEL_ONE);
  c_two: cover property (mode_wr && sel == `EMC_SEL_TWO);
  c_auto: cover property (mode_wr && sel == `EMC_SEL_TWO && mode_word[6]);
  c_odt: cover property (odt_pin && write_burst);
  c_sr: cover property (self_refresh);
endmodule : emc_link_chk

// ---- verif/test_sdram_mode_config_one_two.sv ----
// Purpose: Drives software orders into the controller end and checks the device end.
// Assumes: Both ends share sys_clk; link levels are set through the control word.
// Notes: Expected values come from the field layout, the latency base, DEV_CL and the termination divisor codes.
`timescale 1ns/1ps
`include "emc_consts.svh"
module test_sdram_mode_config_one_two;
  import emc_pkg::*;
  localparam int DEV_CL = 6;
  logic sys_clk;
  logic reset;
  logic [1:0] sw_addr;
  logic [31:0] sw_wdata;
  logic [31:0] sw_rdata;
  logic sw_wr;
  logic sw_rd;
  logic dll_on, dll_reset, dq_out_en_n, tstrobe_term, dm_enable, sr_auto, sr_forced;
  logic [1:0] drive_sel;
  logic [3:0] term_div, add_lat, write_lat;
  logic [12:0] seen_div;
  int errors;
  int total_checks;
  emc_link_if emc_link_if_i ();
  emc_ctrl_end emc_ctrl_end_i (.sys_clk(sys_clk), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .link(emc_link_if_i));
  emc_device_end #(.X8_PART(1'b1), .CL(DEV_CL)) emc_device_end_i (.sys_clk(sys_clk),
    .reset(reset), .link(emc_link_if_i), .dll_on(dll_on), .dll_reset(dll_reset),
    .drive_sel(drive_sel), .dq_out_en_n(dq_out_en_n), .tstrobe_term(tstrobe_term),
    .dm_enable(dm_enable), .term_div(term_div), .add_lat(add_lat), .write_lat(write_lat),
    .self_refresh_2x_auto(sr_auto), .self_refresh_2x_forced(sr_forced));
  emc_link_chk emc_link_chk_i (.sys_clk(sys_clk), .reset(reset),
    .mode_wr(emc_link_if_i.mode_wr), .mode_word(emc_link_if_i.mode_word),
    .banks_idle(emc_link_if_i.banks_idle), .self_refresh(emc_link_if_i.self_refresh),
    .odt_pin(emc_link_if_i.odt_pin), .write_burst(emc_link_if_i.write_burst),
    .read_burst(emc_link_if_i.read_burst));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic sw_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [1:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1;
    chk(sw_rdata, exp);
  endtask : sw_read
  // Loads a word, fires it, lets the hold-off run out, then expects an idle status.
  task automatic mode_write(input emc_word_type w, input logic x16);
    sw_write(`EMC_ADDR_WDATA, {x16, 12'h0, w});
    sw_write(`EMC_ADDR_CTRL, 32'h1);
    repeat (18) @(posedge sys_clk);
    sw_read(`EMC_ADDR_STAT, {29'h0, EMC_IDLE});
  endtask : mode_write
  // Sets the link levels through the control word and waits until the device shows them.
  task automatic set_levels(input logic [3:0] lv);
    sw_write(`EMC_ADDR_CTRL, {27'h0, lv, 1'b0});
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : set_levels
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    results();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    reset = 1'b1;
    sw_addr = 2'h0;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    errors = 0;
    total_checks = 0;
    seen_div = 13'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dll_on, 1'b1);
    chk(dm_enable, 1'b1);
    chk(write_lat, `EMC_CWL_BASE);
    chk(term_div, 4'h0);
    $display("test reset_values done");
    for (int i = 0; i < 3; i++) begin
      mode_write(19'h10000 | 19'(i << 3) | 19'(i % 2 << 1) | 19'(i / 2 << 5), 1'b0);
      chk(add_lat, (i == 0) ? 0 : DEV_CL - i);
      chk(write_lat, 5 + ((i == 0) ? 0 : DEV_CL - i));
      chk(drive_sel, i);
    end
    $display("test latency_drive done");
    for (int c = 1; c < 6; c++) begin
      mode_write(19'h10000 | 19'(c % 2 << 2) | 19'(c / 2 % 2 << 6) | 19'(c / 4 << 9), 1'b0);
      set_levels(4'h2);
      if (term_div < 4'hD) seen_div[term_div] = 1'b1;
    end
    chk(seen_div, 13'h1154);
    $display("test termination done");
    set_levels(4'h0);
    chk(term_div, 4'h0);
    mode_write(19'h20400, 1'b0);
    set_levels(4'h6);
    chk(term_div, 4'h2);
    set_levels(4'hA);
    chk(term_div, 4'h0);
    mode_write(19'h10280, 1'b0);
    set_levels(4'h2);
    chk(term_div, 4'h0);
    mode_write(19'h11280, 1'b0);
    set_levels(4'h2);
    chk(term_div, 4'hC);
    $display("test dynamic_termination done");
    set_levels(4'h1);
    chk(dll_on, 1'b0);
    sw_write(`EMC_ADDR_CTRL, 32'h0);
    @(posedge sys_clk);
    #1;
    chk(dll_reset, 1'b1);
    chk(dll_on, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(dll_reset, 1'b0);
    $display("test self_refresh done");
    mode_write(19'h11822, 1'b0);
    chk(dq_out_en_n, 1'b1);
    chk(tstrobe_term, 1'b1);
    chk(dm_enable, 1'b0);
    chk(drive_sel, 2'h3);
    mode_write(19'h10800, 1'b1);
    chk(tstrobe_term, 1'b0);
    chk(dm_enable, 1'b1);
    chk(dq_out_en_n, 1'b0);
    $display("test qoff_strobe done");
    // Reserved bits and a DLL-off request must both be stripped on the way out.
    mode_write(19'h1E509, 1'b0);
    chk(dll_on, 1'b1);
    chk(add_lat, DEV_CL - 1);
    for (int c = 0; c < 4; c++) begin
      mode_write(19'h20000 | 19'(c << 3), 1'b0);
      chk(write_lat, 5 + c + DEV_CL - 1);
    end
    mode_write(19'h200C0, 1'b0);
    chk(sr_auto, 1'b1);
    chk(sr_forced, 1'b0);
    mode_write(19'h2F987, 1'b0);
    chk(sr_forced, 1'b1);
    chk(write_lat, 5 + DEV_CL - 1);
    chk(add_lat, DEV_CL - 1);
    $display("test word_two done");
    sw_write(2'h3, 32'hFFFFFFFF);
    sw_read(2'h3, 32'h0);
    $display("test unmapped done");
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dll_on, 1'b0);
    chk(write_lat, 4'h5);
    @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(add_lat, 4'h0);
    chk(sr_forced, 1'b0);
    chk(dll_on, 1'b1);
    $display("test mid_reset done");
    results();
  end
endmodule : test_sdram_mode_config_one_two
